// ===== design/temp_readout_pkg.sv
package temp_readout_pkg;
  // register pointers as seen by the serial engine
  localparam logic [7:0]  ADDR_TEMPERATURE_RESULT   = 8'h05;
  localparam logic [7:0]  ADDR_MAKER_IDENTIFICATION = 8'h06;
  localparam logic [7:0]  ADDR_PART_AND_REVISION    = 8'h07;
  localparam logic [7:0]  ADDR_RESOLUTION_SELECT    = 8'h08;
  // result layout
  localparam int          BIT_CRITICAL_ALARM        = 15;
  localparam int          BIT_ABOVE_HIGH            = 14;
  localparam int          BIT_BELOW_LOW             = 13;
  localparam int          BIT_SIGN                  = 12;
  localparam int          CMP_LSB                   = 2;
  localparam int          RES_FIELD_LSB             = 3;
  localparam logic [15:0] RESULT_RESET              = 16'h0000;
  // resolution field encodings
  localparam logic [1:0]  RES_HALF                  = 2'h0;
  localparam logic [1:0]  RES_QUARTER               = 2'h1;
  localparam logic [1:0]  RES_EIGHTH                = 2'h2;
  localparam logic [1:0]  RES_SIXTEENTH             = 2'h3;
  localparam logic [1:0]  RES_RESET                 = RES_QUARTER;
  localparam logic [2:0]  RES_LOW_ONES              = 3'h7;
  // identity values, arbitrary
  localparam logic [15:0] MAKER_ID_VALUE            = 16'h1234;
  localparam logic [7:0]  PART_ID_VALUE             = 8'h5a;
  localparam logic [7:0]  REVISION_VALUE            = 8'h01;
  // conversion timing: worst-case bound 100 ms at 50 MHz
  localparam int          CLK_HZ                    = 50_000_000;
  localparam int          CONV_BOUND_MS             = 100;
  localparam int          CONV_BOUND_CYCLES         = CLK_HZ / 1000 * CONV_BOUND_MS;
endpackage : temp_readout_pkg

// ===== design/alarm_cmp_if.sv
// carries the compare view of temperature and the three limits
interface alarm_cmp_if;
  logic signed [10:0] temp_cmp;
  logic signed [10:0] crit_lim;
  logic signed [10:0] high_lim;
  logic signed [10:0] low_lim;
  logic signed [10:0] hyst;
  logic               crit_d;
  logic               high_d;
  logic               low_d;
  logic               crit_q;
  logic               high_q;
  logic               low_q;
  modport top (output temp_cmp, crit_lim, high_lim, low_lim, hyst, crit_q, high_q, low_q,
               input crit_d, high_d, low_d);
  modport cmp (input temp_cmp, crit_lim, high_lim, low_lim, hyst, crit_q, high_q, low_q,
               output crit_d, high_d, low_d);
endinterface : alarm_cmp_if

// ===== design/alarm_compare.sv
// hysteresis comparators, all in quarter-degree units (bits 12..2)
module alarm_compare (
  alarm_cmp_if.cmp c
);
  logic signed [11:0] temp_w;
  logic signed [11:0] crit_w;
  logic signed [11:0] high_w;
  logic signed [11:0] low_w;
  logic signed [11:0] hyst_w;
  logic signed [11:0] crit_off;
  logic signed [11:0] high_off;
  logic signed [11:0] low_off;

  // signed widening; a concatenation would turn every compare unsigned
  assign temp_w   = 12'(c.temp_cmp);
  assign crit_w   = 12'(c.crit_lim);
  assign high_w   = 12'(c.high_lim);
  assign low_w    = 12'(c.low_lim);
  assign hyst_w   = 12'(c.hyst);
  // one extra bit so limit minus hysteresis cannot wrap
  assign crit_off = crit_w - hyst_w;
  assign high_off = high_w - hyst_w;
  assign low_off  = low_w - hyst_w;

  // set above limit, held until strictly below limit minus hysteresis
  assign c.crit_d = (temp_w > crit_w) | (c.crit_q & ~(temp_w < crit_off));
  // set above limit, cleared at or below limit minus hysteresis
  assign c.high_d = (temp_w > high_w) | (c.high_q & (temp_w > high_off));
  // set below limit minus hysteresis, cleared at or above limit
  assign c.low_d  = (temp_w < low_off) | (c.low_q & (temp_w < low_w));
endmodule : alarm_compare

// ===== design/temp_sensor_readout_regs.sv
// Behaviour
// - read-only result register holds signed temperature plus three alarm flags on top.
// - temperature bits coded like limits, sign bit 12, 128 degrees down to LSB.
// - result bits below the selected resolution read as zero.
// - critical flag sets above limit, clears below limit minus hysteresis.
// - above-high flag sets above high, clears at or below high minus hysteresis.
// - below-low flag sets below low minus hysteresis, clears at or above low.
// - maker identification register returns a fixed 16-bit code.
// - identification register: part code upper byte, revision lower byte.
// - host writes resolution; later conversions use it.
// - field bits 4:3 pick 0.5..0.0625 degree LSB; bits 2:0 read ones.
// - reset selects quarter-degree resolution, register reads 000f.
// - capability resolution field mirrors the selected resolution.
// - each conversion completes within 100 ms, then updates the result.
// - temperature and limits are two's complement.
// - comparisons use only result bits 12 through 2.
module temp_sensor_readout_regs
  import temp_readout_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_BOUND_CYCLES - 1
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        conv_valid,
  input  wire logic [12:0] conv_temp,
  input  wire logic        shutdown,
  input  wire logic [12:0] crit_limit,
  input  wire logic [12:0] high_limit,
  input  wire logic [12:0] low_limit,
  input  wire logic [12:0] hysteresis,
  output logic             conv_start,
  output logic [1:0]       cap_res_field,
  output logic             result_update
);
  logic [1:0]  res_q;
  logic [1:0]  conv_res_q;
  logic [12:0] temp_q;
  logic        crit_alarm_q;
  logic        high_q;
  logic        low_q;
  logic [31:0] timer_q;
  logic        busy_q;
  logic [12:0] temp_masked;
  logic [15:0] rdata_d;
  logic        upd_q;

  alarm_cmp_if c ();

  // register map in short:
  //   05 result: flags on bits 15..13, signed temperature below
  //   06 maker code, fixed, writes ignored
  //   07 part code and revision, fixed, writes ignored
  //   08 resolution field on bits 4:3, bits 2:0 read as ones
  // everything else reads as zero, so a stray pointer is harmless
  // limits, hysteresis and shutdown arrive from logic on this clock,
  // hence no synchroniser stages on them
  // the converter itself is outside this block; only its valid pulse
  // and raw sixteenth-degree result come in here

  // resolution select register, host writable
  // only the two field bits are stored; the low ones are constants
  // a write takes effect at the next conversion start, never mid-way
  // reset value gives quarter-degree steps
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      res_q <= RES_RESET;
    end else if (reg_wr && reg_addr == ADDR_RESOLUTION_SELECT) begin
      res_q <= reg_wdata[RES_FIELD_LSB+1:RES_FIELD_LSB];
    end
  end

  assign cap_res_field = res_q;

  // conversion pacing: start, then wait for the converter or the bound
  // the timer is a safety net: a converter that never answers must not
  // hang the pacing, so the block drops back to idle after the bound
  // and keeps the old result rather than inventing one
  // a conversion already running when shutdown rises still completes;
  // only new starts are held off
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q     <= 1'b0;
      timer_q    <= 32'h0;
      conv_res_q <= RES_RESET;
    end else if (!busy_q) begin
      if (!shutdown) begin
        busy_q     <= 1'b1;
        timer_q    <= 32'h0;
        conv_res_q <= res_q; // latched at start so a mid-conversion write waits for the next one
      end
    end else if (conv_valid || timer_q >= 32'(CONV_CYCLES)) begin
      busy_q <= 1'b0;
    end else begin
      timer_q <= timer_q + 32'h1;
    end
  end

  assign conv_start = !busy_q && !shutdown;

  // drop bits finer than the resolution used for this conversion
  // masking uses the latched resolution, so a write during a conversion
  // cannot give a result with a mix of old and new precision
  // sixteenth steps pass the raw value untouched
  always_comb begin
    temp_masked = conv_temp;
    case (conv_res_q)
      RES_HALF:      temp_masked[2:0] = 3'h0;
      RES_QUARTER:   temp_masked[1:0] = 2'h0;
      RES_EIGHTH:    temp_masked[0]   = 1'b0;
      RES_SIXTEENTH: temp_masked      = conv_temp;
      default:       temp_masked      = conv_temp;
    endcase
  end

  // comparator inputs: quarter-degree view only
  // finer bits never reach the comparators; at half-degree resolution bit 2 is
  // cleared before them too, so flags see half steps; the limits are not masked and keep bit 2 at every resolution
  // the previous flag values feed back for the hysteresis terms
  assign c.temp_cmp = temp_masked[12:CMP_LSB];
  assign c.crit_lim = crit_limit[12:CMP_LSB];
  assign c.high_lim = high_limit[12:CMP_LSB];
  assign c.low_lim  = low_limit[12:CMP_LSB];
  assign c.hyst     = hysteresis[12:CMP_LSB];
  assign c.crit_q   = crit_alarm_q;
  assign c.high_q   = high_q;
  assign c.low_q    = low_q;

  alarm_compare u_cmp (
    .c (c)
  );

  // result and flags captured in one edge; no torn reads
  // a valid pulse while idle is ignored: nothing was asked for, and a
  // stray pulse must not overwrite a good reading
  // flags only move on a new result, never on a limit change alone,
  // a limitation the host must allow for after reprogramming limits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      temp_q       <= RESULT_RESET[12:0];
      crit_alarm_q <= 1'b0;
      high_q       <= 1'b0;
      low_q        <= 1'b0;
      upd_q        <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      if (busy_q && conv_valid) begin
        temp_q       <= temp_masked;
        crit_alarm_q <= c.crit_d;
        high_q       <= c.high_d;
        low_q        <= c.low_d;
        upd_q        <= 1'b1;
      end
    end
  end

  assign result_update = upd_q;

  // read mux
  // identity values are fixed constants; writes to them are dropped
  // the result view is the stored word, never the converter input
  always_comb begin
    case (reg_addr)
      ADDR_TEMPERATURE_RESULT:   rdata_d = {crit_alarm_q, high_q, low_q, temp_q};
      ADDR_MAKER_IDENTIFICATION: rdata_d = MAKER_ID_VALUE;
      ADDR_PART_AND_REVISION:    rdata_d = {PART_ID_VALUE, REVISION_VALUE};
      ADDR_RESOLUTION_SELECT:    rdata_d = {11'h000, res_q, RES_LOW_ONES};
      default:                   rdata_d = 16'h0000;
    endcase
  end

  // read data registered one cycle after the address
  // costs one cycle of latency but keeps the read path free of the
  // comparator logic, and the host sees a steady word for a full cycle
  // while the pointer stands
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end
endmodule : temp_sensor_readout_regs

// ===== test/temp_readout_chk.sv
module temp_readout_chk
  import temp_readout_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        conv_valid,
  input wire logic        shutdown,
  input wire logic        conv_start,
  input wire logic [1:0]  cap_res_field,
  input wire logic        result_update
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // reads answer one cycle after the pointer; the past mirror is what got registered
  a_res_read:
    assert property (reg_addr == ADDR_RESOLUTION_SELECT && !reg_wr |=>
      reg_rdata == {11'h000, $past(cap_res_field), RES_LOW_ONES}) else $error("resolution read wrong");
  a_maker_read:
    assert property (reg_addr == ADDR_MAKER_IDENTIFICATION |=> reg_rdata == MAKER_ID_VALUE) else $error("maker read");
  a_part_read:
    assert property (reg_addr == ADDR_PART_AND_REVISION |=> reg_rdata == {PART_ID_VALUE, REVISION_VALUE})
      else $error("part read");
  // resolution field follows writes only
  a_res_write:
    assert property (reg_wr && reg_addr == ADDR_RESOLUTION_SELECT |=> cap_res_field == $past(reg_wdata[4:3]))
      else $error("resolution write lost");
  a_res_hold:
    assert property (!(reg_wr && reg_addr == ADDR_RESOLUTION_SELECT) |=> $stable(cap_res_field))
      else $error("mirror moved");
  // update pulse tied to a result taken while busy
  a_upd_taken:
    assert property (conv_valid && !conv_start && !shutdown |=> result_update) else $error("no update");
  a_upd_cause:
    assert property (result_update |-> $past(conv_valid)) else $error("update without result");
  a_upd_single:
    assert property (result_update |=> !result_update) else $error("update too long");
endmodule : temp_readout_chk

bind temp_sensor_readout_regs temp_readout_chk chk_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_valid(conv_valid), .shutdown(shutdown),
  .conv_start(conv_start), .cap_res_field(cap_res_field), .result_update(result_update));

// ===== test/conv_model.sv
module conv_model #(
  parameter int DLY = 6
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        conv_start,
  input  wire logic [12:0] temp,
  output logic             conv_valid,
  output logic [12:0]      conv_temp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       on_q;
  logic [7:0] cnt_q;
  // one result per start request, far inside the bound
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      conv_valid <= 1'b0;
      on_q       <= 1'b0;
      cnt_q      <= 8'h00;
    end else if (!on_q) begin
      conv_valid <= 1'b0;
      on_q  <= conv_start;
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(DLY)) begin
      conv_valid <= 1'b1;
      on_q       <= 1'b0;
    end else begin
      conv_valid <= 1'b0;
      cnt_q      <= cnt_q + 8'h01;
    end
  end
  // data flipped outside the strobe so a late sample shows up
  assign conv_temp = conv_valid ? temp : ~temp;
endmodule : conv_model

// ===== test/testbench.sv
module testbench
  import temp_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, arst_n, reg_wr, conv_valid, shutdown, conv_start, result_update;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [12:0] temp, conv_temp;
  logic [1:0]  cap_res_field;
  int          n_mismatch, checks_done;
  temp_sensor_readout_regs #(.CONV_CYCLES(50)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_temp(conv_temp),
    .shutdown(shutdown), .crit_limit(13'h0500), .high_limit(13'h03c0), .low_limit(13'h00a0), .hysteresis(13'h0020),
    .conv_start(conv_start), .cap_res_field(cap_res_field), .result_update(result_update));
  conv_model cm_u (.clk_sys(clk_sys), .arst_n(arst_n), .conv_start(conv_start), .temp(temp),
    .conv_valid(conv_valid), .conv_temp(conv_temp));
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // pointer out, one edge to register, then sample
  task automatic rdchk(logic [7:0] a, logic [15:0] exp);
    @(posedge clk_sys) reg_addr <= a;
    @(posedge clk_sys) #1 chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask : rdchk
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : wr
  // two updates so the new value is surely taken
  task automatic conv(logic [12:0] t);
    int i;
    @(posedge clk_sys) temp <= t;
    #1;
    repeat (2) begin
      i = 0;
      while (i < 100 && result_update !== 1'b1) begin
        @(posedge clk_sys) #1;
        i++;
      end
      if (i >= 100) begin
        n_mismatch++;
        $display("Error result_update expected 1 seen %b", result_update);
      end
      @(posedge clk_sys) #1;
    end
  endtask : conv
  task automatic t_reset;
    rdchk(ADDR_RESOLUTION_SELECT, 16'h000f);
    chk("cap", 16'h0001, {14'h0, cap_res_field});
    rdchk(ADDR_TEMPERATURE_RESULT, 16'h0000);
    wr(ADDR_MAKER_IDENTIFICATION, 16'hffff);
    rdchk(ADDR_MAKER_IDENTIFICATION, MAKER_ID_VALUE);
    rdchk(ADDR_PART_AND_REVISION, {PART_ID_VALUE, REVISION_VALUE});
    rdchk(8'h09, 16'h0000);
  endtask : t_reset
  task automatic t_res;
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_RESOLUTION_SELECT, {11'h0, 2'(r), 3'h0});
      rdchk(ADDR_RESOLUTION_SELECT, {11'h0, 2'(r), 3'h7});
      chk("cap", 16'(r), {14'h0, cap_res_field});
      conv(13'h019f);
      rdchk(ADDR_TEMPERATURE_RESULT, {3'h0, 13'h019f & (13'h1fff << (3 - r))});
    end
  endtask : t_res
  // walk through set and hysteresis clear of each flag, limits 80/60/10, hysteresis 2
  task automatic t_alarm;
    int       tdeg[12] = '{20, 61, 59, 58, 81, 79, 77, 9, 7, 9, 10, -5};
    bit [2:0] tflg[12] = '{0, 2, 2, 0, 6, 6, 2, 0, 1, 1, 0, 1};
    for (int k = 0; k < 12; k++) begin
      conv(13'(tdeg[k] * 16));
      rdchk(ADDR_TEMPERATURE_RESULT, {tflg[k], 13'(tdeg[k] * 16)});
    end
  endtask : t_alarm
  // shutdown stops new conversions; the one in flight ends at 16 degrees, then stays
  task automatic t_shut;
    @(posedge clk_sys) {shutdown, temp} <= {1'b1, 13'h0100};
    repeat (30) @(posedge clk_sys);
    chk("start", 16'h0000, {15'h0, conv_start});
    rdchk(ADDR_TEMPERATURE_RESULT, {3'h0, 13'h0100});
    @(posedge clk_sys) shutdown <= 1'b0;
  endtask : t_shut
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    {arst_n, reg_wr, shutdown, reg_addr, reg_wdata, temp} = '0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_res();
    t_alarm();
    t_shut();
    summarize();
  end
endmodule : testbench
